// file: shared/spc_regs.svh
// Register offsets, field positions and reset values of the port register bank
`ifndef SPC_REGS_SVH
`define SPC_REGS_SVH
`define SPC_CMD_OFS 8'h18
`define SPC_TFD_OFS 8'h20
`define SPC_START_BIT 0
`define SPC_SPINUP_BIT 1
`define SPC_POWER_BIT 2
`define SPC_OVR_BIT 3
`define SPC_RXEN_BIT 4
`define SPC_SLOT_LSB 8
`define SPC_SLOT_MSB 12
`define SPC_RUN_BIT 15
`define SPC_ERR_LSB 8
`define SPC_ERR_MSB 15
`define SPC_STS_LSB 0
`define SPC_STS_MSB 7
`define SPC_BUSY_BIT 7
`define SPC_DREQ_BIT 3
`define SPC_ERRF_BIT 0
`define SPC_STATUS_RST 8'h7F
`define SPC_ERROR_RST 8'h00
`define SPC_SLOT_RST 5'h00
`define SPC_DET_LISTEN 4'h0
`endif

// file: shared/spc_pkg.sv
// Types shared by the port register bank
package spc_pkg;
  typedef enum logic [1:0] {
    SPC_FIS_D2H,
    SPC_FIS_PIO,
    SPC_FIS_SDB,
    SPC_FIS_OTHER
  } spc_fis_kind_t;

  typedef struct packed {
    logic valid;
    spc_fis_kind_t kind;
    logic [7:0] status;
    logic [7:0] error;
  } spc_fis_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } spc_req_t;

  typedef enum logic [1:0] {
    SPC_IDLE,
    SPC_RUN,
    SPC_STOP
  } spc_list_state_t;
endpackage

// file: core/spc_port_regs.sv
// Port command and task-file mirror register bank with list start control
// Behaviour
// - Override write forces busy and request low
// - Override self-clears once both flags are zero
// - Writing zero to override does nothing
// - Power bit writable only with cold presence
// - Power bit drives the power pin high
// - Spin-up bit writable only with staggered cap
// - Spin-up rise starts a link reset
// - Spin-up fall sends no link signal
// - Spin-up low, detect zero: listen mode
// - List processed only while start is one
// - Start rise restarts list at slot zero
// - Start fall clears issue once controller idle
// - Mirror refreshed by three FIS kinds
// - Error byte holds latest error, resets zero
// - Status byte holds latest status, resets 7F
// - D2H and PIO updates overwrite all eight status bits; SDB keeps busy and request
// - Upper sixteen mirror bits read zero
// - Start fall resets current slot to zero
// - Running flag shows list engine active
//
// Decided for this implementation: the plain strobed port.
`include "spc_regs.svh"

module spc_port_regs (
  input wire logic mclk_i,
  input wire logic rst_i,
  input spc_pkg::spc_req_t req_i,
  output logic [31:0] rdata_o,
  input wire logic cold_presence_supported_i,
  input wire logic staggered_spinup_cap_i,
  input wire logic [3:0] serial_ctrl_detect_field_i,
  input spc_pkg::spc_fis_t fis_i,
  input wire logic ctrl_idle_i,
  input wire logic slot_load_i,
  input wire logic [4:0] slot_i,
  output logic cmd_fetch_en_o,
  output logic list_restart_o,
  output logic issue_clear_o,
  output logic list_running_o,
  output logic fis_receive_enable_o,
  output logic power_pin_o,
  output logic comreset_o,
  output logic listen_mode_o,
  output logic busy_flag_o,
  output logic data_request_flag_o,
  output logic error_flag_o
);
  import spc_pkg::*;

  logic list_start_r;
  logic spin_up_device_r;
  logic device_power_on_r;
  logic list_override_r;
  logic fis_receive_enable_r;
  logic [4:0] current_slot_r;
  logic [7:0] status_byte_r;
  logic [7:0] error_byte_r;
  logic [7:0] status_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [31:0] cmd_view;
  logic [31:0] tfd_view;
  logic spin_prev_r;
  logic comreset_r;
  logic listen_r;
  logic power_pin_r;
  logic restart_r;
  logic issue_clr_r;
  spc_list_state_t state_r;
  spc_list_state_t state_nxt;

  logic wr_cmd;
  logic ovr_set;
  logic fis_acc;
  logic spin_view;
  logic power_view;
  logic flags_clear;

  assign wr_cmd = req_i.wr && (req_i.addr == `SPC_CMD_OFS);
  assign ovr_set = wr_cmd && req_i.wdata[`SPC_OVR_BIT];
  assign fis_acc = fis_i.valid && (fis_i.kind != SPC_FIS_OTHER);
  assign flags_clear = !status_byte_r[`SPC_BUSY_BIT] && !status_byte_r[`SPC_DREQ_BIT];

  // Read-only value when the capability is absent
  assign power_view = cold_presence_supported_i ? device_power_on_r : 1'b1;
  assign spin_view = staggered_spinup_cap_i ? spin_up_device_r : 1'b1;

  // Plain control bits
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      list_start_r <= 1'b0;
      fis_receive_enable_r <= 1'b0;
    end else if (wr_cmd) begin
      list_start_r <= req_i.wdata[`SPC_START_BIT];
      fis_receive_enable_r <= req_i.wdata[`SPC_RXEN_BIT];
    end
  end

  // Capability gated bits
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      device_power_on_r <= 1'b0;
      spin_up_device_r <= 1'b0;
    end else if (wr_cmd) begin
      if (cold_presence_supported_i) begin
        device_power_on_r <= req_i.wdata[`SPC_POWER_BIT];
      end
      if (staggered_spinup_cap_i) begin
        spin_up_device_r <= req_i.wdata[`SPC_SPINUP_BIT];
      end
    end
  end

  // Override bit: set by a one, cleared by hardware, set wins
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      list_override_r <= 1'b0;
    end else if (ovr_set) begin
      list_override_r <= 1'b1;
    end else if (list_override_r && flags_clear) begin
      list_override_r <= 1'b0;
    end
  end

  // Next status byte from FIS and override
  always_comb begin
    status_nxt = status_byte_r;
    if (fis_acc) begin
      status_nxt = fis_i.status;
      if (fis_i.kind == SPC_FIS_SDB) begin
        status_nxt[`SPC_BUSY_BIT] = status_byte_r[`SPC_BUSY_BIT];
        status_nxt[`SPC_DREQ_BIT] = status_byte_r[`SPC_DREQ_BIT];
      end
    end
    if (ovr_set) begin
      status_nxt[`SPC_BUSY_BIT] = 1'b0;
      status_nxt[`SPC_DREQ_BIT] = 1'b0;
    end
  end

  // Task-file mirror, both bytes in one edge
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      status_byte_r <= `SPC_STATUS_RST;
      error_byte_r <= `SPC_ERROR_RST;
    end else begin
      status_byte_r <= status_nxt;
      if (fis_acc) begin
        error_byte_r <= fis_i.error;
      end
    end
  end

  // List engine sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SPC_IDLE: begin
        if (list_start_r) begin
          state_nxt = SPC_RUN;
        end
      end
      SPC_RUN: begin
        if (!list_start_r) begin
          state_nxt = SPC_STOP;
        end
      end
      SPC_STOP: begin
        if (ctrl_idle_i) begin
          state_nxt = SPC_IDLE;
        end
      end
      default: begin
        state_nxt = SPC_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= SPC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Start and stop pulses toward the controller
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      restart_r <= 1'b0;
      issue_clr_r <= 1'b0;
    end else begin
      restart_r <= (state_r == SPC_IDLE) && list_start_r;
      issue_clr_r <= (state_r == SPC_STOP) && ctrl_idle_i;
    end
  end

  // Current slot
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      current_slot_r <= `SPC_SLOT_RST;
    end else if (state_r == SPC_RUN && !list_start_r) begin
      current_slot_r <= `SPC_SLOT_RST;
    end else if (state_r == SPC_IDLE && list_start_r) begin
      current_slot_r <= `SPC_SLOT_RST;
    end else if (slot_load_i && state_r == SPC_RUN) begin
      current_slot_r <= slot_i;
    end
  end

  // Link side controls
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      spin_prev_r <= 1'b0;
      comreset_r <= 1'b0;
      listen_r <= 1'b0;
      power_pin_r <= 1'b0;
    end else begin
      spin_prev_r <= spin_view;
      comreset_r <= spin_view && !spin_prev_r;
      listen_r <= !spin_view && (serial_ctrl_detect_field_i == `SPC_DET_LISTEN);
      power_pin_r <= power_view;
    end
  end

  // Register views
  always_comb begin
    cmd_view = '0;
    cmd_view[`SPC_START_BIT] = list_start_r;
    cmd_view[`SPC_SPINUP_BIT] = spin_view;
    cmd_view[`SPC_POWER_BIT] = power_view;
    cmd_view[`SPC_OVR_BIT] = list_override_r;
    cmd_view[`SPC_RXEN_BIT] = fis_receive_enable_r;
    cmd_view[`SPC_SLOT_MSB:`SPC_SLOT_LSB] = current_slot_r;
    cmd_view[`SPC_RUN_BIT] = (state_r != SPC_IDLE);
  end

  always_comb begin
    tfd_view = '0;
    tfd_view[`SPC_ERR_MSB:`SPC_ERR_LSB] = error_byte_r;
    tfd_view[`SPC_STS_MSB:`SPC_STS_LSB] = status_byte_r;
  end

  always_comb begin
    rdata_nxt = '0;
    if (req_i.addr == `SPC_CMD_OFS) begin
      rdata_nxt = cmd_view;
    end else if (req_i.addr == `SPC_TFD_OFS) begin
      rdata_nxt = tfd_view;
    end else begin
      rdata_nxt = '0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= req_i.rd ? rdata_nxt : '0;
    end
  end

  assign rdata_o = rdata_r;
  assign cmd_fetch_en_o = list_start_r && (state_r == SPC_RUN);
  assign list_restart_o = restart_r;
  assign issue_clear_o = issue_clr_r;
  assign list_running_o = (state_r != SPC_IDLE);
  assign fis_receive_enable_o = fis_receive_enable_r;
  assign power_pin_o = power_pin_r;
  assign comreset_o = comreset_r;
  assign listen_mode_o = listen_r;
  assign busy_flag_o = status_byte_r[`SPC_BUSY_BIT];
  assign data_request_flag_o = status_byte_r[`SPC_DREQ_BIT];
  assign error_flag_o = status_byte_r[`SPC_ERRF_BIT];

  // Checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  ovr_forces_flags_a: assert property (
    ovr_set |=> !busy_flag_o && !data_request_flag_o ##1 !list_override_r)
    else $error("override did not clear flags");

  ovr_self_clear_a: assert property (
    list_override_r && flags_clear && !ovr_set |=> !list_override_r)
    else $error("override did not self clear");

  ovr_zero_write_a: assert property (
    wr_cmd && !req_i.wdata[`SPC_OVR_BIT] && !fis_acc
    |=> status_byte_r == $past(status_byte_r)
    && list_override_r == ($past(list_override_r) && !$past(flags_clear)))
    else $error("zero write changed override");

  power_ro_a: assert property (
    !cold_presence_supported_i |-> cmd_view[`SPC_POWER_BIT])
    else $error("power bit not one without cold presence");

  power_pin_a: assert property (
    ##1 power_pin_o == $past(power_view))
    else $error("power pin does not follow power bit");

  spin_ro_a: assert property (
    !staggered_spinup_cap_i |-> cmd_view[`SPC_SPINUP_BIT])
    else $error("spin-up bit not one without staggered cap");

  comreset_rise_a: assert property (
    spin_view && !spin_prev_r |=> comreset_o ##1 !comreset_o)
    else $error("no single link reset pulse on spin-up");

  no_oob_fall_a: assert property (
    !spin_view |=> !comreset_o)
    else $error("link reset sent with spin-up low");

  listen_mode_a: assert property (
    !spin_view && serial_ctrl_detect_field_i == `SPC_DET_LISTEN |=> listen_mode_o)
    else $error("listen mode not entered");

  fetch_gate_a: assert property (
    !list_start_r |-> !cmd_fetch_en_o)
    else $error("list fetched with start low");

  restart_slot_a: assert property (
    state_r == SPC_IDLE && list_start_r |=> list_restart_o && current_slot_r == 5'h00)
    else $error("start rise did not restart at slot zero");

  issue_clear_a: assert property (
    state_r == SPC_STOP && ctrl_idle_i |=> issue_clear_o && !list_running_o)
    else $error("issue not cleared at idle");

  sdb_keeps_a: assert property (
    fis_acc && fis_i.kind == SPC_FIS_SDB && !ovr_set
    |=> busy_flag_o == $past(busy_flag_o) && error_byte_r == $past(fis_i.error)
    && data_request_flag_o == $past(data_request_flag_o))
    else $error("set device bits FIS changed busy");

  status_full_a: assert property (
    fis_acc && fis_i.kind != SPC_FIS_SDB && !ovr_set |=> status_byte_r == $past(fis_i.status))
    else $error("status byte not fully overwritten");

  rsvd_zero_a: assert property (
    rdata_o[31:16] == 16'h0000)
    else $error("reserved mirror bits not zero");

  slot_reset_a: assert property (
    state_r == SPC_RUN && !list_start_r |=> current_slot_r == 5'h00 ##1 !cmd_fetch_en_o)
    else $error("slot not reset on start fall");

  running_flag_a: assert property (
    state_r == SPC_IDLE && list_start_r |=> list_running_o)
    else $error("running flag not set");

  error_latest_a: assert property (
    fis_acc |=> error_byte_r == $past(fis_i.error))
    else $error("error byte not latest");

  issue_pulse_a: assert property (
    issue_clear_o |=> !issue_clear_o)
    else $error("issue clear longer than one cycle");

  restart_pulse_a: assert property (
    list_restart_o |=> !list_restart_o)
    else $error("restart longer than one cycle");

  listen_off_a: assert property (
    spin_view |=> !listen_mode_o)
    else $error("listen mode with spin-up high");

  ovr_cycle_c: cover property (ovr_set ##1 list_override_r ##1 !list_override_r);
  slot_load_c: cover property (slot_load_i && state_r == SPC_RUN);
  comreset_c: cover property (comreset_o);
  stop_idle_c: cover property (state_r == SPC_STOP ##[1:20] issue_clear_o);
  sdb_update_c: cover property (fis_acc && fis_i.kind == SPC_FIS_SDB);

endmodule

// file: verif/spc_drive_model.sv
// Behavioural drive on the far side of the link, answering resets with a FIS
module spc_drive_model (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic comreset_i,
  input wire logic send_i,
  input spc_pkg::spc_fis_kind_t kind_i,
  input wire logic [7:0] status_i,
  input wire logic [7:0] error_i,
  output spc_pkg::spc_fis_t fis_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import spc_pkg::*;
  int cnt_r;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 0;
      fis_o <= '0;
    end else begin
      fis_o.valid <= 1'b0;
      fis_o.status <= ~fis_o.status;
      fis_o.error <= ~fis_o.error;
      if (comreset_i) begin
        cnt_r <= 8;
      end else if (cnt_r > 1) begin
        cnt_r <= cnt_r - 1;
      end else if (cnt_r == 1) begin
        cnt_r <= 0;
        fis_o <= '{valid: 1'b1, kind: SPC_FIS_D2H, status: 8'h50, error: 8'h01};
      end else if (send_i) begin
        fis_o <= '{valid: 1'b1, kind: kind_i, status: status_i, error: error_i};
      end
    end
  end
endmodule

// file: verif/spc_port_regs_tb.sv
// Register-level bench for the port register bank
`include "spc_regs.svh"
module spc_port_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import spc_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  spc_req_t req = '0;
  logic [31:0] rdata_o;
  logic cps = 1'b1, ssc = 1'b1, idle = 1'b1, sload = 1'b0, send = 1'b0;
  logic [3:0] det = 4'h0;
  logic [4:0] slot = 5'h05;
  spc_fis_kind_t kind = SPC_FIS_D2H;
  logic [7:0] st = 8'h00, er = 8'h00;
  spc_fis_t fis;
  logic fetch, rs, clr, run, fis_receive_enable, pwr, cr, lsn, busy_flag, data_request_flag, erf;
  int err_count = 0, checks = 0, n_cr = 0, n_rs = 0, n_cl = 0;
  spc_fis_kind_t ks[4] = '{SPC_FIS_D2H, SPC_FIS_SDB, SPC_FIS_OTHER, SPC_FIS_PIO};
  logic [7:0] ss[4] = '{8'h89, 8'h40, 8'h11, 8'h76};
  logic [7:0] es[4] = '{8'h00, 8'h22, 8'h33, 8'h05};
  logic [31:0] xs[4] = '{32'h0000_0089, 32'h0000_22C8, 32'h0000_22C8, 32'h0000_0576};

  always #5 mclk_i = ~mclk_i;
  always @(negedge mclk_i) begin
    if (cr) n_cr++;
    if (rs) n_rs++;
    if (clr) n_cl++;
  end

  spc_port_regs dut (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata_o),
    .cold_presence_supported_i(cps), .staggered_spinup_cap_i(ssc),
    .serial_ctrl_detect_field_i(det), .fis_i(fis), .ctrl_idle_i(idle),
    .slot_load_i(sload), .slot_i(slot), .cmd_fetch_en_o(fetch), .list_restart_o(rs),
    .issue_clear_o(clr), .list_running_o(run), .fis_receive_enable_o(fis_receive_enable),
    .power_pin_o(pwr), .comreset_o(cr), .listen_mode_o(lsn), .busy_flag_o(busy_flag),
    .data_request_flag_o(data_request_flag), .error_flag_o(erf));
  spc_drive_model drive (.mclk_i(mclk_i), .rst_i(rst_i), .comreset_i(cr), .send_i(send),
    .kind_i(kind), .status_i(st), .error_i(er), .fis_o(fis));

  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_i) req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge mclk_i) req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_i) req.rd <= 1'b0;
    #1 chk(n, rdata_o, e);
  endtask
  task automatic fs(input spc_fis_kind_t k, input logic [7:0] s, input logic [7:0] r);
    @(posedge mclk_i) begin
      send <= 1'b1;
      kind <= k;
      st <= s;
      er <= r;
    end
    @(posedge mclk_i) send <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #100us;
    err_count++;
    close_out;
  end

  initial begin
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    chk("listen", {31'h0, lsn}, 32'h1);
    chk("reset flags", {29'h0, busy_flag, data_request_flag, erf}, 32'h3);
    rd(`SPC_TFD_OFS, 32'h0000_007F, "tfd reset");
    rd(`SPC_CMD_OFS, 32'h0000_0000, "cmd reset");
    rd(8'h40, 32'h0000_0000, "unmapped");
    $display("test reset done");
    wr(`SPC_CMD_OFS, 32'h0000_0006);
    repeat (2) @(posedge mclk_i);
    chk("power pin", {31'h0, pwr}, 32'h1);
    chk("comreset", n_cr, 1);
    chk("listen off", {31'h0, lsn}, 32'h0);
    repeat (12) @(posedge mclk_i);
    rd(`SPC_TFD_OFS, 32'h0000_0150, "tfd after reset fis");
    wr(`SPC_CMD_OFS, 32'h0000_0004);
    repeat (3) @(posedge mclk_i);
    chk("no comreset", n_cr, 1);
    chk("listen on", {31'h0, lsn}, 32'h1);
    cps <= 1'b0;
    ssc <= 1'b0;
    wr(`SPC_CMD_OFS, 32'h0000_0000);
    rd(`SPC_CMD_OFS, 32'h0000_0006, "fixed bits");
    chk("comreset cap", n_cr, 2);
    repeat (12) @(posedge mclk_i);
    $display("test link done");
    for (int i = 0; i < 4; i++) begin
      fs(ks[i], ss[i], es[i]);
      rd(`SPC_TFD_OFS, xs[i], "tfd fis");
    end
    chk("err flag", {29'h0, busy_flag, data_request_flag, erf}, 32'h0);
    $display("test fis done");
    wr(`SPC_CMD_OFS, 32'h0000_0016);
    fs(SPC_FIS_D2H, 8'h88, 8'h00);
    chk("rx enable", {31'h0, fis_receive_enable}, 32'h1);
    chk("flags set", {30'h0, busy_flag, data_request_flag}, 32'h3);
    wr(`SPC_CMD_OFS, 32'h0000_001E);
    #1 chk("flags forced", {30'h0, busy_flag, data_request_flag}, 32'h0);
    repeat (2) @(posedge mclk_i);
    rd(`SPC_CMD_OFS, 32'h0000_0016, "override clear");
    rd(`SPC_TFD_OFS, 32'h0000_0000, "tfd forced");
    wr(`SPC_CMD_OFS, 32'h0000_0017);
    fs(SPC_FIS_D2H, 8'h80, 8'h00);
    idle <= 1'b0;
    wr(`SPC_CMD_OFS, 32'h0000_0017);
    rd(`SPC_TFD_OFS, 32'h0000_0080, "zero override");
    $display("test override done");
    chk("restart", n_rs, 1);
    chk("run fetch", {30'h0, run, fetch}, 32'h3);
    @(posedge mclk_i) sload <= 1'b1;
    @(posedge mclk_i) sload <= 1'b0;
    rd(`SPC_CMD_OFS, 32'h0000_8517, "slot");
    wr(`SPC_CMD_OFS, 32'h0000_0016);
    repeat (3) @(posedge mclk_i);
    chk("fetch off", {31'h0, fetch}, 32'h0);
    chk("no clear", n_cl, 0);
    rd(`SPC_CMD_OFS, 32'h0000_8016, "stop slot");
    @(posedge mclk_i) idle <= 1'b1;
    repeat (4) @(posedge mclk_i);
    chk("issue clear", n_cl, 1);
    rd(`SPC_CMD_OFS, 32'h0000_0016, "stopped");
    wr(`SPC_CMD_OFS, 32'h0000_0017);
    repeat (3) @(posedge mclk_i);
    chk("restart again", n_rs, 2);
    rd(`SPC_CMD_OFS, 32'h0000_8017, "slot zero");
    $display("test list done");
    close_out;
  end
endmodule
